// *** cfd_pkg.sv ***
// package: constants and carrier types of the channel fault diagnosis block
package cfd_pkg;

  localparam int NCH   = 8;
  localparam int CNT_W = 16;

  // timing
  localparam int CLK_MHZ       = 200;
  localparam int OVL_DELAY_US  = 60;
  localparam int OVL_DELAY_CYC = OVL_DELAY_US * CLK_MHZ;
  localparam int OL_DELAY_US   = 100;
  localparam int OL_DELAY_CYC  = OL_DELAY_US * CLK_MHZ;
  // sync stages and the trip edge, taken out of the overload count
  localparam int OVL_PIPE_CYC  = 3;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROT = 8'h04;
  localparam logic [7:0] OFS_OL   = 8'h08;
  localparam logic [7:0] OFS_DIAG_CURRENT_CONTROL_REGISTER = 8'h0C;
  localparam logic [7:0] OFS_STS  = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;

  // field positions
  localparam int CTRL_CPL_BIT   = 0;
  localparam int CTRL_ONREQ_LSB = 8;
  localparam int PROT_ON_LSB    = 8;
  localparam int STS_OL_LSB     = 8;

  // reset values
  localparam logic [NCH-1:0]   RST_ONREQ = 8'h00;
  localparam logic [NCH-1:0]   RST_DCEN  = 8'h00;
  localparam logic [2*NCH-1:0] RST_MASK  = 16'h0000;

  typedef struct packed {
    logic             on;
    logic             prot;
    logic             ol;
    logic [CNT_W-1:0] ovl_cnt;
    logic [CNT_W-1:0] ol_cnt;
  } cfd_chan_st_t;

  typedef struct packed {
    logic on;
    logic prot;
    logic ol;
    logic prot_evt;
    logic ol_evt;
  } cfd_chan_stat_t;

  typedef struct packed {
    logic [3*NCH-1:0] s1;
    logic [3*NCH-1:0] s2;
  } cfd_sync_st_t;

  typedef struct packed {
    logic             clear_protection_latch;
    logic [NCH-1:0]   on_req;
    logic [NCH-1:0]   dcen;
    logic [2*NCH-1:0] sts;
    logic [2*NCH-1:0] mask;
    logic             ack;
    logic [31:0]      dat;
    logic             irq;
  } cfd_top_st_t;

endpackage

// *** cfd_sync.sv ***
// two flip-flop synchroniser for the sense pins
module cfd_sync import cfd_pkg::*; (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [3*NCH-1:0] d_i,
  output logic      [3*NCH-1:0] q_o
);
  cfd_sync_st_t st_ff;
  cfd_sync_st_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d_i;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.s2;
endmodule

// *** cfd_chan.sv ***
// one output channel: protection latch, overload delay, open-load detection
module cfd_chan import cfd_pkg::*; #(
  parameter int OVL_CYC = OVL_DELAY_CYC,
  parameter int OL_CYC  = OL_DELAY_CYC
) (
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  input  wire logic     on_req_i,
  input  wire logic     over_temp_i,
  input  wire logic     overload_i,
  input  wire logic     ol_sense_i,
  input  wire logic     cpl_clr_i,
  input  wire logic     ol_rd_clr_i,
  output cfd_chan_stat_t stat_o
);
  localparam logic [CNT_W-1:0] OVL_LAST = CNT_W'(OVL_CYC - OVL_PIPE_CYC);
  localparam logic [CNT_W-1:0] OL_LAST  = CNT_W'(OL_CYC - 1);

  cfd_chan_st_t st_ff;
  cfd_chan_st_t nxt_st;
  logic         trip;
  logic         prot_set;
  logic         ol_hit;

  always_comb begin
    nxt_st = st_ff;
    trip   = 1'b0;
    ol_hit = 1'b0;
    if (st_ff.on && overload_i) begin
      if (st_ff.ovl_cnt == OVL_LAST) begin
        trip = 1'b1;
      end else begin
        nxt_st.ovl_cnt = st_ff.ovl_cnt + 1'b1;
      end
    end else begin
      nxt_st.ovl_cnt = '0;
    end
    prot_set = over_temp_i | trip;
    if (prot_set) begin
      nxt_st.prot = 1'b1;
    end else if (cpl_clr_i) begin
      nxt_st.prot = 1'b0;
    end
    nxt_st.on = on_req_i & ~nxt_st.prot;
    if (st_ff.on || !ol_sense_i) begin
      nxt_st.ol_cnt = '0;
    end else if (st_ff.ol_cnt == OL_LAST) begin
      ol_hit = 1'b1;
    end else begin
      nxt_st.ol_cnt = st_ff.ol_cnt + 1'b1;
    end
    if (ol_hit) begin
      nxt_st.ol = 1'b1;
    end else if (ol_rd_clr_i) begin
      nxt_st.ol = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign stat_o.on       = st_ff.on;
  assign stat_o.prot     = st_ff.prot;
  assign stat_o.ol       = st_ff.ol;
  assign stat_o.prot_evt = prot_set & ~st_ff.prot;
  assign stat_o.ol_evt   = ol_hit & ~st_ff.ol;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ovl_trip_off: assert property (
    st_ff.on && overload_i && st_ff.ovl_cnt == OVL_LAST
    |=> !st_ff.on && st_ff.prot)
    else $error("overload did not shut the channel off");
  a_ovl_not_early: assert property (
    $rose(st_ff.prot) && !$past(over_temp_i)
    |-> $past(st_ff.ovl_cnt) == OVL_LAST)
    else $error("overload trip before the shutdown delay");
  a_ol_after_delay: assert property (
    $rose(st_ff.ol) |-> $past(st_ff.ol_cnt) == OL_LAST && !$past(st_ff.on))
    else $error("open-load flag set without full delay in off state");
endmodule

// *** cfd_top.sv ***
// channel fault diagnosis flags with a classic wishbone register slave
//
// The register addresses and register access over Wishbone were left to the implementer.
module cfd_top import cfd_pkg::*; #(
  parameter int OVL_CYC = OVL_DELAY_CYC,
  parameter int OL_CYC  = OL_DELAY_CYC
) (
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [3:0]     wb_sel_i,
  input  wire logic [7:0]     wb_adr_i,
  input  wire logic [31:0]    wb_dat_i,
  output logic      [31:0]    wb_dat_o,
  output logic                wb_ack_o,
  input  wire logic [NCH-1:0] over_temp_i,
  input  wire logic [NCH-1:0] overload_i,
  input  wire logic [NCH-1:0] open_load_sense_i,
  output logic      [NCH-1:0] channel_on_o,
  output logic      [NCH-1:0] diag_current_enable_o,
  output logic                irq_o
);
  cfd_top_st_t      st_ff;
  cfd_top_st_t      nxt_st;
  logic [3*NCH-1:0] sense_sync;
  logic [NCH-1:0]   temp_s;
  logic [NCH-1:0]   ovl_s;
  logic [NCH-1:0]   ols_s;
  logic [NCH-1:0]   chan_on;
  logic [NCH-1:0]   prot_flag;
  logic [NCH-1:0]   open_load_flag;
  logic [NCH-1:0]   prot_evt;
  logic [NCH-1:0]   ol_evt;
  logic             take;
  logic             wr;
  logic             rd;
  logic             cpl_wr;
  logic             ol_rd;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  cfd_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({open_load_sense_i, overload_i, over_temp_i}),
    .q_o   (sense_sync)
  );

  assign temp_s = sense_sync[NCH-1:0];
  assign ovl_s  = sense_sync[2*NCH-1:NCH];
  assign ols_s  = sense_sync[3*NCH-1:2*NCH];

  ////////////////////////////////////////////////////////////////////////////
  // channels

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      cfd_chan_stat_t stat;

      cfd_chan #(
        .OVL_CYC (OVL_CYC),
        .OL_CYC  (OL_CYC)
      ) u_chan (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .on_req_i    (st_ff.on_req[g]),
        .over_temp_i (temp_s[g]),
        .overload_i  (ovl_s[g]),
        .ol_sense_i  (ols_s[g]),
        .cpl_clr_i   (cpl_wr),
        .ol_rd_clr_i (ol_rd),
        .stat_o      (stat)
      );

      assign chan_on[g]        = stat.on;
      assign prot_flag[g]      = stat.prot;
      assign open_load_flag[g] = stat.ol;
      assign prot_evt[g]       = stat.prot_evt;
      assign ol_evt[g]         = stat.ol_evt;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign take   = wb_cyc_i & wb_stb_i & ~st_ff.ack;
  assign wr     = take & wb_we_i;
  assign rd     = take & ~wb_we_i;
  assign cpl_wr = wr && wb_adr_i[7:2] == OFS_CTRL[7:2] && wb_sel_i[0]
                  && wb_dat_i[CTRL_CPL_BIT];
  assign ol_rd  = rd && wb_adr_i[7:2] == OFS_OL[7:2];

  ////////////////////////////////////////////////////////////////////////////
  // register file

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.ack = take;
    nxt_st.dat = '0;
    if (take && st_ff.clear_protection_latch) begin
      nxt_st.clear_protection_latch = 1'b0;
    end
    if (cpl_wr) begin
      nxt_st.clear_protection_latch = 1'b1;
    end
    if (wr) begin
      case (wb_adr_i[7:2])
        OFS_CTRL[7:2]: begin
          if (wb_sel_i[1]) begin
            nxt_st.on_req = wb_dat_i[CTRL_ONREQ_LSB +: NCH];
          end
        end
        OFS_DIAG_CURRENT_CONTROL_REGISTER[7:2]: begin
          if (wb_sel_i[0]) begin
            nxt_st.dcen = wb_dat_i[NCH-1:0];
          end
        end
        OFS_STS[7:2]: begin
          if (wb_sel_i[0]) begin
            nxt_st.sts[NCH-1:0] = st_ff.sts[NCH-1:0] & ~wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            nxt_st.sts[2*NCH-1:NCH] = st_ff.sts[2*NCH-1:NCH] & ~wb_dat_i[15:8];
          end
        end
        OFS_MASK[7:2]: begin
          if (wb_sel_i[0]) begin
            nxt_st.mask[NCH-1:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            nxt_st.mask[2*NCH-1:NCH] = wb_dat_i[15:8];
          end
        end
        default: begin
        end
      endcase
    end
    if (rd) begin
      case (wb_adr_i[7:2])
        OFS_CTRL[7:2]: nxt_st.dat = {16'h0000, st_ff.on_req, 7'h00, st_ff.clear_protection_latch};
        OFS_PROT[7:2]: nxt_st.dat = {16'h0000, chan_on, prot_flag};
        OFS_OL[7:2]:   nxt_st.dat = {24'h000000, open_load_flag};
        OFS_DIAG_CURRENT_CONTROL_REGISTER[7:2]: nxt_st.dat = {24'h000000, st_ff.dcen};
        OFS_STS[7:2]:  nxt_st.dat = {16'h0000, st_ff.sts};
        OFS_MASK[7:2]: nxt_st.dat = {16'h0000, st_ff.mask};
        default:       nxt_st.dat = '0;
      endcase
    end
    // events are ored in after the clear so a coincident set wins
    nxt_st.sts[NCH-1:0]        = nxt_st.sts[NCH-1:0] | prot_evt;
    nxt_st.sts[STS_OL_LSB +: NCH] = nxt_st.sts[STS_OL_LSB +: NCH] | ol_evt;
    nxt_st.irq = |(nxt_st.sts & nxt_st.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff        <= '0;
      st_ff.on_req <= RST_ONREQ;
      st_ff.dcen   <= RST_DCEN;
      st_ff.mask   <= RST_MASK;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o              = st_ff.dat;
  assign wb_ack_o              = st_ff.ack;
  assign channel_on_o          = chan_on;
  assign diag_current_enable_o = st_ff.dcen;
  assign irq_o                 = st_ff.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_prot_sticky: assert property (
    (|($past(prot_flag) & ~prot_flag)) |-> $past(cpl_wr))
    else $error("protection flag dropped without a clear command");

  a_cpl_clears: assert property (
    cpl_wr && temp_s == '0 && ovl_s == '0 |=> prot_flag == '0)
    else $error("clear command left a protection flag set");

  a_cpl_selfclear: assert property (
    st_ff.clear_protection_latch && take && !cpl_wr |=> !st_ff.clear_protection_latch ##1 !st_ff.clear_protection_latch)
    else $error("clear bit did not return to zero");

  a_ol_independent: assert property (
    cpl_wr && !ol_rd
    |=> (open_load_flag & $past(open_load_flag)) == $past(open_load_flag))
    else $error("clear command disturbed open-load flags");

  a_ol_read_clear: assert property (
    ol_rd |=> wb_ack_o && (open_load_flag & ~$past(ols_s & ~chan_on)) == '0)
    else $error("open-load read did not clear the flags");

  a_ol_not_on: assert property (
    (open_load_flag & ~$past(open_load_flag) & $past(chan_on)) == '0)
    else $error("open-load flag set while channel on");

  a_dcen_write: assert property (
    wr && wb_adr_i[7:2] == OFS_DIAG_CURRENT_CONTROL_REGISTER[7:2] && wb_sel_i[0]
    |=> diag_current_enable_o == $past(wb_dat_i[NCH-1:0]))
    else $error("diagnosis current enable not written");

  a_temp_off: assert property (
    temp_s != '0
    |=> (prot_flag & $past(temp_s)) == $past(temp_s)
        && (chan_on & $past(temp_s)) == '0)
    else $error("over temperature did not latch and switch off");

  a_fault_holds_off: assert property (
    (prot_flag & chan_on) == '0)
    else $error("channel on while its protection flag is set");

  a_irq_level: assert property (
    st_ff.ack |-> irq_o == |(st_ff.sts & st_ff.mask))
    else $error("interrupt output does not follow status and mask");

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake and register fields

  a_ack_answers: assert property (
    take |=> wb_ack_o)
    else $error("taken request was not acknowledged");

  a_ack_one_cycle: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge stood longer than one cycle");

  a_dat_idle_zero: assert property (
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data not zero outside the acknowledge cycle");

  a_unmapped_zero: assert property (
    rd && wb_adr_i[7:2] > OFS_MASK[7:2]
    |=> wb_dat_o == '0)
    else $error("unmapped offset did not read zero");

  a_onreq_write: assert property (
    wr && wb_adr_i[7:2] == OFS_CTRL[7:2] && wb_sel_i[1]
    |=> st_ff.on_req == $past(wb_dat_i[CTRL_ONREQ_LSB +: NCH]))
    else $error("switch-on request not written");

  a_dcen_stable: assert property (
    !(wr && wb_adr_i[7:2] == OFS_DIAG_CURRENT_CONTROL_REGISTER[7:2])
    |=> $stable(diag_current_enable_o))
    else $error("diagnosis current enable changed without a write");

  a_mask_write: assert property (
    wr && wb_adr_i[7:2] == OFS_MASK[7:2] && wb_sel_i[0]
    |=> st_ff.mask[NCH-1:0] == $past(wb_dat_i[7:0]))
    else $error("mask not written");

  ////////////////////////////////////////////////////////////////////////////
  // flags and status events

  a_cpl_raise: assert property (
    cpl_wr |=> st_ff.clear_protection_latch)
    else $error("clear bit does not read one after the command");

  a_ol_read_data: assert property (
    ol_rd |=> wb_dat_o == {24'h000000, $past(open_load_flag)})
    else $error("open-load read did not return the flags");

  a_sts_prot_set: assert property (
    (|prot_evt)
    |=> (st_ff.sts[NCH-1:0] & $past(prot_evt)) == $past(prot_evt))
    else $error("protection event not recorded in status");

  a_sts_ol_set: assert property (
    (|ol_evt)
    |=> (st_ff.sts[STS_OL_LSB +: NCH] & $past(ol_evt)) == $past(ol_evt))
    else $error("open-load event not recorded in status");

  a_sts_w1c: assert property (
    wr && wb_adr_i[7:2] == OFS_STS[7:2] && wb_sel_i[0] && prot_evt == '0
    |=> (st_ff.sts[NCH-1:0] & $past(wb_dat_i[7:0])) == '0)
    else $error("write one did not clear the status bits");

  c_trip: cover property ($rose(|prot_flag) && $past(chan_on) != '0);
  c_cpl_recover: cover property (cpl_wr ##[1:20] $rose(|chan_on));
  c_ol_readback: cover property ($rose(|open_load_flag) ##[1:50] ol_rd);
  c_irq: cover property ($rose(irq_o));
  c_sts_clear: cover property (wr && wb_adr_i[7:2] == OFS_STS[7:2] && wb_sel_i[0]);
endmodule

// *** cfd_load_model.sv ***
// model of the loads and sense circuits that stand behind the eight channel outputs
module cfd_load_model import cfd_pkg::*; (
  input  wire logic           clk_i,
  input  wire logic [NCH-1:0] channel_on_i,
  input  wire logic [NCH-1:0] short_req_i,
  input  wire logic [NCH-1:0] hot_req_i,
  input  wire logic [NCH-1:0] open_req_i,
  output logic      [NCH-1:0] over_temp_o,
  output logic      [NCH-1:0] overload_o,
  output logic      [NCH-1:0] open_load_sense_o
);
  // a shorted load draws overcurrent only while its channel conducts
  always_ff @(posedge clk_i) begin
    overload_o        <= short_req_i & channel_on_i;
    over_temp_o       <= hot_req_i;
    open_load_sense_o <= open_req_i;
  end
endmodule

// *** cfd_top_test.sv ***
// self-checking testbench of the channel fault diagnosis block
module cfd_top_test import cfd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OVL = 8;
  localparam int OL  = 6;
  logic           clk_i;
  logic           rst_i;
  logic           cyc;
  logic           stb;
  logic           we;
  logic [3:0]     sel;
  logic [7:0]     adr;
  logic [31:0]    wdat;
  logic [31:0]    rdat;
  logic           ack;
  logic [NCH-1:0] temp;
  logic [NCH-1:0] ovl;
  logic [NCH-1:0] ols;
  logic [NCH-1:0] chan_on;
  logic [NCH-1:0] dcen;
  logic           irq;
  logic [NCH-1:0] short_req;
  logic [NCH-1:0] hot_req;
  logic [NCH-1:0] open_req;
  logic [31:0]    q;
  int             fails;
  int             cmp_count;

  cfd_top #(.OVL_CYC(OVL), .OL_CYC(OL)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .over_temp_i(temp), .overload_i(ovl), .open_load_sense_i(ols),
    .channel_on_o(chan_on), .diag_current_enable_o(dcen), .irq_o(irq)
  );
  cfd_load_model load_u (
    .clk_i(clk_i), .channel_on_i(chan_on), .short_req_i(short_req), .hot_req_i(hot_req),
    .open_req_i(open_req), .over_temp_o(temp), .overload_o(ovl), .open_load_sense_o(ols)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle; waits for ack without assuming its latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) begin
      fails++;
      conclude();
    end
  endtask

  // read a register until any bit under m is set, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      wb(1'b0, a, 32'h0);
      n++;
    end while ((q & m) === 32'h0 && n < 200);
    if (n >= 200) begin
      fails++;
      conclude();
    end
  endtask

  // the switch-on request byte shares the control word, so it is rewritten too
  task automatic clear_latch(input logic [7:0] on);
    wb(1'b1, OFS_CTRL, {16'h0000, on, 8'h01});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] ofs [7] = '{OFS_CTRL, OFS_PROT, OFS_OL, OFS_DIAG_CURRENT_CONTROL_REGISTER, OFS_STS, OFS_MASK, 8'h1C};
    chk("outputs", {8'h0, chan_on, dcen, 7'h0, irq}, 32'h0);
    foreach (ofs[i]) begin
      wb(1'b0, ofs[i], 32'h0);
      chk("reset read", q, 32'h0);
    end
    $display("test reset done");
  endtask

  task automatic t_diag_current_control_register;
    wb(1'b1, OFS_DIAG_CURRENT_CONTROL_REGISTER, 32'h0000_00A5);
    wb(1'b0, OFS_DIAG_CURRENT_CONTROL_REGISTER, 32'h0);
    chk("diag_current_control_register read", q, 32'h0000_00A5);
    chk("dcen pins", {24'h0, dcen}, 32'h0000_00A5);
    $display("test diag current done");
  endtask

  task automatic t_temp;
    wb(1'b1, OFS_CTRL, 32'h0000_FF00);
    @(posedge clk_i);
    chk("all on", {24'h0, chan_on}, 32'h0000_00FF);
    hot_req <= 8'h04;
    poll(OFS_PROT, 32'h0000_0004);
    chk("temp prot", q, 32'h0000_FB04);
    hot_req <= 8'h00;
    repeat (10) @(posedge clk_i);
    wb(1'b1, OFS_CTRL, 32'h0000_FF00);
    wb(1'b0, OFS_PROT, 32'h0);
    chk("latched off", q, 32'h0000_FB04);
    clear_latch(8'hFF);
    wb(1'b0, OFS_CTRL, 32'h0);
    chk("clear bit set", q, 32'h0000_FF01);
    wb(1'b0, OFS_PROT, 32'h0);
    chk("cleared", q, 32'h0000_FF00);
    wb(1'b0, OFS_CTRL, 32'h0);
    chk("clear bit", q, 32'h0000_FF00);
    wb(1'b1, OFS_CTRL, 32'h0);
    hot_req <= 8'h80;
    poll(OFS_PROT, 32'h0000_0080);
    chk("temp off", q, 32'h0000_0080);
    hot_req <= 8'h00;
    repeat (4) @(posedge clk_i);
    clear_latch(8'h00);
    $display("test over temperature done");
  endtask

  task automatic t_ovl;
    int n;
    wb(1'b1, OFS_CTRL, 32'h0000_FF00);
    short_req <= 8'h20;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (chan_on[5] !== 1'b0 && n < 100);
    chk("delay min", 32'(n >= OVL), 32'h1);
    chk("delay max", 32'(n <= OVL + 2), 32'h1);
    chk("others on", {24'h0, chan_on}, 32'h0000_00DF);
    wb(1'b0, OFS_PROT, 32'h0);
    chk("ovl prot", q, 32'h0000_DF20);
    short_req <= 8'h00;
    clear_latch(8'h00);
    $display("test overload done");
  endtask

  task automatic t_ol;
    wb(1'b1, OFS_CTRL, 32'h0000_0800);
    wb(1'b0, OFS_OL, 32'h0);
    open_req <= 8'h0A;
    poll(OFS_STS, 32'h0000_0200);
    open_req <= 8'h00;
    repeat (4) @(posedge clk_i);
    wb(1'b0, OFS_OL, 32'h0);
    chk("ol flag", q, 32'h0000_0002);
    wb(1'b0, OFS_OL, 32'h0);
    chk("ol read clear", q, 32'h0);
    wb(1'b0, OFS_PROT, 32'h0);
    chk("prot apart", q, 32'h0000_0800);
    $display("test open load done");
  endtask

  task automatic t_irq;
    wb(1'b1, OFS_STS, 32'h0000_FFFF);
    wb(1'b0, OFS_STS, 32'h0);
    chk("sts clear", q, 32'h0);
    wb(1'b1, OFS_MASK, 32'h0000_0001);
    hot_req <= 8'h01;
    repeat (8) @(posedge clk_i);
    chk("irq up", {31'h0, irq}, 32'h1);
    wb(1'b1, OFS_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wb(1'b1, OFS_MASK, 32'h0000_0001);
    wb(1'b1, OFS_STS, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    hot_req <= 8'h00;
    repeat (4) @(posedge clk_i);
    clear_latch(8'h00);
    $display("test interrupt done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; sel = 4'h0; adr = 8'h00;
    wdat = 32'h0; short_req = 8'h00; hot_req = 8'h00; open_req = 8'h00;
    fails = 0; cmp_count = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_diag_current_control_register();
    t_temp();
    t_ovl();
    t_ol();
    t_irq();
    conclude();
  end
endmodule
